/* File: logic/gpa_pkg.sv */
// Constants shared by the port A control logic.
// Assumes an 8-bit register port with byte-wide data.
package gpa_pkg;
  localparam int GPA_WIDTH = 8;
  localparam int GPA_ADDR_W = 4;
  // Register offsets
  localparam logic [3:0] GPA_OFS_DIR_PIN = 4'h0;
  localparam logic [3:0] GPA_OFS_OUT_DATA = 4'h1;
  localparam logic [3:0] GPA_OFS_CONTROL = 4'h2;
  // Reset values
  localparam logic [7:0] GPA_DIR_RESET = 8'h00;
  localparam logic [7:0] GPA_OUT_RESET = 8'h00;
  localparam logic [7:0] GPA_CTRL_RESET = 8'h00;
  // Control register fields
  localparam int GPA_CTRL_EXTERNAL_EXPANSION_ENABLE_BIT = 0;
  localparam int GPA_CTRL_IO_STROBE_SELECT_BIT = 1;
  localparam int GPA_CTRL_KEYBOARD_PIN_ENABLE_BIT = 2;
  localparam int GPA_CTRL_MODE_LSB = 4;
  localparam logic [7:0] GPA_CTRL_MASK = 8'h37;
  // Keyboard pins are the upper six
  localparam int GPA_KB_LSB = 2;
  // Operating modes
  localparam logic [1:0] GPA_MODE_1 = 2'h1;
  localparam logic [1:0] GPA_MODE_2 = 2'h2;
  localparam logic [1:0] GPA_MODE_3 = 2'h3;
  // Pin roles
  typedef enum logic [3:0] {
    GPA_ROLE_IN = 4'h1,
    GPA_ROLE_OUT = 4'h2,
    GPA_ROLE_ADDR = 4'h4,
    GPA_ROLE_KBD = 4'h8
  } gpa_role_e;
endpackage

/* File: logic/gpa_sync.sv */
// Two-stage synchroniser for the port pin levels.
// Assumes pins are asynchronous to clk_sys.
`timescale 1ns/1ps
module gpa_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_stage1 = rstn ? d : '0;
    next_q = rstn ? stage1 : '0;
  end

  always_ff @(posedge clk_sys) begin
    stage1 <= next_stage1;
    q <= next_q;
  end
endmodule

/* File: logic/gpa_pin_mux.sv */
// Per-pin role selection and drive for one port pin.
// Assumes control inputs are already registered on clk_sys.
`timescale 1ns/1ps
module gpa_pin_mux
  import gpa_pkg::*;
(
  // Configuration
  input wire logic [1:0] mode,
  input wire logic external_expansion_enable,
  input wire logic io_strobe_select,
  input wire logic kb_pin,
  // Per-pin values
  input wire logic dir_bit,
  input wire logic out_bit,
  input wire logic addr_bit,
  input wire logic kbd_out,
  // Results
  output gpa_pkg::gpa_role_e role,
  output logic drive_val,
  output logic drive_oe_n
);
  always_comb begin
    if (kb_pin) begin
      role = GPA_ROLE_KBD;
    end else if (mode == GPA_MODE_2 && external_expansion_enable && dir_bit
                 && !io_strobe_select) begin
      role = GPA_ROLE_ADDR;
    end else if (dir_bit) begin
      role = GPA_ROLE_OUT;
    end else begin
      role = GPA_ROLE_IN;
    end
  end

  always_comb begin
    drive_val = 1'b0;
    drive_oe_n = 1'b1;
    unique case (role)
      GPA_ROLE_IN: begin
        drive_oe_n = 1'b1;
      end
      GPA_ROLE_OUT: begin
        drive_val = out_bit;
        drive_oe_n = 1'b0;
      end
      GPA_ROLE_ADDR: begin
        drive_val = addr_bit;
        drive_oe_n = 1'b0;
      end
      // Open drain: only a low is driven
      GPA_ROLE_KBD: begin
        drive_val = 1'b0;
        drive_oe_n = kbd_out;
      end
      default: begin
        drive_oe_n = 1'b1;
      end
    endcase
  end
endmodule

/* File: logic/gpa_port.sv */
// Port A control: direction, output data, pin-state read and pin roles.
// Assumes a single-cycle register port and asynchronous pins.
//
// Functional notes
// - Eight bidirectional pins, each set to input or output separately.
// - Each direction bit controls only its own pin.
// - Modes 1, 3, and 2 without expansion: 1 is output, 0 input.
// - Mode 2 with expansion: 1 drives address output, 0 is input.
// - Expanded mode 2 with strobe select: set bits give port outputs.
// - Keyboard enable hands the upper six pins to the keyboard logic.
// - Direction is write-only; reading its address returns pin states.
// - Output data always readable and writable, whatever the directions.
// - Output data is driven onto pins configured as port outputs.
// - Writing the pin-state address updates the direction bits.
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module gpa_port
  import gpa_pkg::*;
#(
  parameter int WIDTH = gpa_pkg::GPA_WIDTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [gpa_pkg::GPA_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Address bus and keyboard controller
  input wire logic [WIDTH-1:0] addr_out,
  input wire logic [WIDTH-1:0] kbd_drive_low_n,
  // Pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_n,
  // Status
  output logic [1:0] mode,
  output logic [WIDTH-1:0] pin_level
);
  import gpa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [WIDTH-1:0] port_direction;
  logic [WIDTH-1:0] port_output_data_reg;
  logic [7:0] control;
  logic [WIDTH-1:0] next_direction;
  logic [WIDTH-1:0] next_output_data;
  logic [7:0] next_control;
  logic [7:0] next_rdata;
  logic external_expansion_enable;
  logic io_strobe_select;
  logic keyboard_pin_enable;
  logic [WIDTH-1:0] port_pin_state_reg;

  function automatic logic hit(input logic [GPA_ADDR_W-1:0] a,
                               input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  assign external_expansion_enable = control[GPA_CTRL_EXTERNAL_EXPANSION_ENABLE_BIT];
  assign io_strobe_select = control[GPA_CTRL_IO_STROBE_SELECT_BIT];
  assign keyboard_pin_enable = control[GPA_CTRL_KEYBOARD_PIN_ENABLE_BIT];
  assign mode = control[GPA_CTRL_MODE_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling
  // pins synchronised every cycle
  gpa_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(pin_in),
    .q(port_pin_state_reg)
  );
  assign pin_level = port_pin_state_reg;

  ////////////////////////////////////////////////////////////////////////
  // Register writes and reads
  always_comb begin
    next_direction = port_direction;
    next_output_data = port_output_data_reg;
    next_control = control;
    next_rdata = 8'h00;
    if (reg_wr) begin
      if (hit(reg_addr, GPA_OFS_DIR_PIN)) begin
        next_direction = reg_wdata[WIDTH-1:0];
      end
      if (hit(reg_addr, GPA_OFS_OUT_DATA)) begin
        next_output_data = reg_wdata[WIDTH-1:0];
      end
      if (hit(reg_addr, GPA_OFS_CONTROL)) begin
        next_control = reg_wdata & GPA_CTRL_MASK;
      end
    end
    if (reg_rd) begin
      if (hit(reg_addr, GPA_OFS_DIR_PIN)) begin
        next_rdata[WIDTH-1:0] = port_pin_state_reg;
      end else if (hit(reg_addr, GPA_OFS_OUT_DATA)) begin
        next_rdata[WIDTH-1:0] = port_output_data_reg;
      end else if (hit(reg_addr, GPA_OFS_CONTROL)) begin
        next_rdata = control;
      end
    end
    if (!rstn) begin
      next_direction = GPA_DIR_RESET;
      next_output_data = GPA_OUT_RESET;
      next_control = GPA_CTRL_RESET;
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    port_direction <= next_direction;
    port_output_data_reg <= next_output_data;
    control <= next_control;
    reg_rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin role per bit
  // one mux per pin
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      gpa_pin_mux u_mux (
        .mode(mode),
        .external_expansion_enable(external_expansion_enable),
        .io_strobe_select(io_strobe_select),
        .kb_pin(keyboard_pin_enable && (i >= GPA_KB_LSB)),
        .dir_bit(port_direction[i]),
        .out_bit(port_output_data_reg[i]),
        .addr_bit(addr_out[i]),
        .kbd_out(kbd_drive_low_n[i]),
        .role(),
        .drive_val(pin_out[i]),
        .drive_oe_n(pin_oe_n[i])
      );
    end
  endgenerate
endmodule

/* File: verif/gpa_port_assertions.sv */
// Checker bound to gpa_port.
// Assumes it sees only top-level ports.
`timescale 1ns/1ps
module gpa_port_assertions
  import gpa_pkg::*;
(
  // Clock and register port
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [GPA_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic [7:0] addr_out,
  input wire logic [7:0] kbd_drive_low_n,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pin_level
);
  logic [7:0] dir, odr, ctl;
  logic xp, kb;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Shadow copies of the written registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {dir, odr, ctl} <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        GPA_OFS_DIR_PIN: dir <= reg_wdata;
        GPA_OFS_OUT_DATA: odr <= reg_wdata;
        GPA_OFS_CONTROL: ctl <= reg_wdata;
        default: ;
      endcase
    end
  end
  assign xp = ctl[5:4] == GPA_MODE_2 && ctl[GPA_CTRL_EXTERNAL_EXPANSION_ENABLE_BIT];
  assign kb = ctl[GPA_CTRL_KEYBOARD_PIN_ENABLE_BIT];
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_odr_rd; reg_rd && reg_addr == GPA_OFS_OUT_DATA |=> reg_rdata == $past(odr);
  endproperty
  a_odr_rd: assert property (p_odr_rd) else $error("output data read");
  property p_pin_rd; reg_rd && reg_addr == GPA_OFS_DIR_PIN |=> reg_rdata == $past(pin_level);
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin state read");
  property p_rst; $rose(rstn) |-> pin_oe_n == 8'hFF; endproperty
  a_rst: assert property (p_rst) else $error("pins not inputs");
  property p_gpio; !kb && !xp |-> pin_oe_n == ~dir; endproperty
  a_gpio: assert property (p_gpio) else $error("direction");
  property p_out; !kb && !(xp && !ctl[1]) |-> ((pin_out ^ odr) & dir) == 8'h00; endproperty
  a_out: assert property (p_out) else $error("output data drive");
  property p_addr; !kb && xp && !ctl[1] |-> pin_oe_n == ~dir
    && ((pin_out ^ addr_out) & dir) == 8'h00; endproperty
  a_addr: assert property (p_addr) else $error("address drive");
  property p_io_strobe_select; !kb && xp && ctl[1] |-> pin_oe_n == ~dir; endproperty
  a_io_strobe_select: assert property (p_io_strobe_select) else $error("strobe select");
  property p_kbd; kb |-> pin_oe_n[7:2] == kbd_drive_low_n[7:2] && pin_out[7:2] == 6'h00;
  endproperty
  a_kbd: assert property (p_kbd) else $error("keyboard pins");
endmodule
bind gpa_port gpa_port_assertions i_gpa_port_assertions (.clk_sys(clk_sys), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .addr_out(addr_out), .kbd_drive_low_n(kbd_drive_low_n),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));

/* File: verif/gpa_board.sv */
// Board model of the port pins.
// Assumes active-low output enables.
`timescale 1ns/1ps
module gpa_board (
  // Port drive
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  // Board drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Pin levels
  output logic [7:0] pin_in
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule

/* File: verif/gpa_port_tb_top.sv */
// Testbench for gpa_port.
// Assumes the board model and bound checker.
`timescale 1ns/1ps
module gpa_port_tb_top;
  import gpa_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00, addr_out = 8'h00, kbd_n = 8'hFF, ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00, reg_rdata, pin_in, pin_out, pin_oe_n, pin_level;
  logic [1:0] mode;
  int errors = 0, checks = 0, cycles = 0;
  always #20 clk_sys = ~clk_sys;
  gpa_port i_gpa_port (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .addr_out(addr_out), .kbd_drive_low_n(kbd_n), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .mode(mode), .pin_level(pin_level));
  gpa_board i_gpa_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask
  task automatic t_reset;
    chk("oe_n", pin_oe_n, 8'hFF);
    rd("out_data", GPA_OFS_OUT_DATA, GPA_OUT_RESET);
    rd("pins", GPA_OFS_DIR_PIN, 8'hFF);
    rd("unmapped", 4'hF, 8'h00);
  endtask
  task automatic t_gpio;
    ext_en <= 8'hF0;
    ext_val <= 8'h30;
    wr(GPA_OFS_OUT_DATA, 8'hA5);
    wr(GPA_OFS_DIR_PIN, 8'h0F);
    chk("oe_n", pin_oe_n, 8'hF0);
    chk("out", pin_out & 8'h0F, 8'h05);
    repeat (3) @(posedge clk_sys);
    rd("pins", GPA_OFS_DIR_PIN, 8'h35);
    chk("pin_level", pin_level, 8'h35);
    rd("out_data", GPA_OFS_OUT_DATA, 8'hA5);
  endtask
  task automatic t_expand;
    logic [7:0] ctl [6] = '{8'h10, 8'h11, 8'h20, 8'h21, 8'h23, 8'h31};
    logic [7:0] exp [6] = '{8'h05, 8'h05, 8'h05, 8'h03, 8'h05, 8'h05};
    @(posedge clk_sys);
    addr_out <= 8'hC3;
    for (int i = 0; i < 6; i++) begin
      wr(GPA_OFS_CONTROL, ctl[i]);
      chk("out", pin_out & 8'h0F, exp[i]);
    end
    chk("mode", {6'h00, mode}, {6'h00, GPA_MODE_3});
  endtask
  task automatic t_kbd;
    @(posedge clk_sys);
    kbd_n <= 8'h5A;
    wr(GPA_OFS_CONTROL, 8'hC4);
    chk("kbd_oe_n", pin_oe_n, 8'h58);
    chk("kbd_out", pin_out, 8'h01);
    rd("control", GPA_OFS_CONTROL, 8'hC4 & GPA_CTRL_MASK);
  endtask
  task automatic t_rerun;
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk("oe_n", pin_oe_n, 8'hFF);
    chk("mode", {6'h00, mode}, 8'h00);
    rd("out_data", GPA_OFS_OUT_DATA, GPA_OUT_RESET);
    rd("pins", GPA_OFS_DIR_PIN, 8'h3F);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_gpio();
    t_expand();
    t_kbd();
    t_rerun();
    conclude();
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      conclude();
    end
  end
endmodule
